// [bench/adcc_dp_model.sv]
`timescale 1ns/1ps
module adcc_dp_model #(
  parameter int DLY = 20
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                mod_hold_rst,
  input  wire adcc_pkg::adcc_src_e conv_src,
  input  wire logic [23:0]         level,
  input  wire logic                err,
  output adcc_pkg::adcc_main_s     main_out
);
  int cnt_r;

  // Conversion timer, stopped while the modulator is held
  always_ff @(posedge clk) begin
    if (rst || mod_hold_rst) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= (cnt_r == DLY - 1) ? 0 : cnt_r + 1;
    end
  end

  // Output word depends on the source; garbage between outputs
  always_comb begin
    main_out.valid     = !mod_hold_rst && cnt_r == DLY - 1;
    main_out.data      = main_out.valid ?
                         level ^ {conv_src, 22'h0} : ~level;
    main_out.range_err = main_out.valid && err;
    main_out.thresh    = main_out.valid && err;
  end
endmodule // adcc_dp_model

// [bench/test_adc_mode_calibration_step_detect.sv]
`timescale 1ns/1ps
`include "adcc_consts.svh"
module test_adc_mode_calibration_step_detect;
  localparam logic [23:0] OFS_F = 24'h0a_5a5a;
  localparam logic [23:0] GN_F  = 24'h41_0203;
  logic                 clk = 0;
  logic                 rst = 1;
  adcc_pkg::adcc_req_s  bus = '0;
  adcc_pkg::adcc_main_s main_in;
  adcc_pkg::adcc_src_e  conv_src;
  logic [31:0]          rdata;
  logic [15:0]          fast_in = 16'h0;
  logic [23:0]          level = 24'h0;
  logic [7:0]           filt_rate;
  logic                 pga_unity = 0, err = 0, rd_seen = 0;
  logic                 vpo = 0, vno = 0, vlow = 0, ce = 1;
  logic                 adc_pwr_on, mod_hold_rst, main_sinc4;
  logic                 fast_run, irq_adc, irq_step, irq_dma;
  logic [31:0]          eq[$], mq[$];
  int                   fails = 0, checks = 0, cyc = 0, n, nv, nd;

  adcc_ctrl #(.FAST_BASE_CYC(8), .OFFSET_FACT(OFS_F), .GAIN_FACT(GN_F))
  adcc_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .main_in(main_in), .fast_in(fast_in), .pga_unity(pga_unity),
    .vref_pos_open(vpo), .vref_neg_open(vno), .vref_low(vlow),
    .adc_pwr_on(adc_pwr_on), .mod_hold_rst(mod_hold_rst),
    .main_sinc4(main_sinc4), .fast_run(fast_run), .filt_rate(filt_rate),
    .conv_src(conv_src), .irq_adc(irq_adc), .irq_step(irq_step),
    .irq_dma(irq_dma));

  adcc_dp_model #(.DLY(20)) adcc_dp_model_i (.clk(clk), .rst(rst),
    .mod_hold_rst(mod_hold_rst), .conv_src(conv_src), .level(level),
    .err(err), .main_out(main_in));

  // Clock and cycle ceiling
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (main_in.valid === 1'b1) nv++;
    if (irq_dma === 1'b1) nd++;
    if (cyc == 40000) begin
      fails++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Read answers matched against the oldest note
  always @(posedge clk) rd_seen <= bus.rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      chk((rdata & mq.pop_front()) === eq.pop_front(), "read data");
    end
  end

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    eq.push_back(e & m);
    mq.push_back(m);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
  endtask

  task automatic idle(input int k);
    bus <= '0;
    repeat (k) @(posedge clk);
  endtask

  // Bounded waits on the design's outputs and on the model's main output valid
  task automatic wait_idle();
    idle(2);
    n = 0;
    while (mod_hold_rst !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(n < 500, "conversion end");
  endtask

  task automatic wait_valid();
    bus <= '0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (main_in.valid !== 1'b1 && n < 100);
    chk(n < 100, "main output");
  endtask

  task automatic wait_tick(output realtime t);
    idle(1);
    n = 0;
    while (irq_adc !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    t = $realtime;
    chk(n < 300, "fast tick");
  endtask

  task automatic tick(output realtime t);
    rd(`ADCC_A_DETECTION_STATUS, 32'h0, 32'h0);
    wait_tick(t);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [1:0]  src;
    logic [15:0] x;
    logic [9:0]  th;
    realtime     t1, t2;
    r = $urandom(27);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ADCC_A_MODE, 32'h3);
    rd(`ADCC_A_OFFSET, {8'h0, OFS_F});
    rd(`ADCC_A_GAIN_INT, {8'h0, GN_F});
    rd(`ADCC_A_GAIN_EXT, 32'h0);
    rd(`ADCC_A_GAIN_SUP, 32'h0);
    rd(`ADCC_A_STEP_THRESHOLD, 32'h0);
    rd(4'hd, 32'h0);
    idle(2);
    chk(adc_pwr_on === 1'b1 && mod_hold_rst === 1'b1, "idle");
    $display("test reset done");

    level <= 24'($urandom);
    err   <= 1'b1;
    wr(`ADCC_A_MODE, 32'h2);
    idle(2);
    chk(mod_hold_rst === 1'b0, "single start");
    wait_idle();
    err <= 1'b0;
    rd(`ADCC_A_RESULT, {8'h0, level});
    rd(`ADCC_A_STATUS, 32'h15);
    rd(`ADCC_A_STATUS, 32'h0);
    rd(`ADCC_A_MODE, 32'h3);
    $display("test single done");

    r = $urandom;
    wr(`ADCC_A_FILT, {24'h0, r[7:0]});
    idle(2);
    chk(filt_rate === r[7:0] && main_sinc4 === r[7], "filter");
    wr(`ADCC_A_MODE, 32'h1);
    wr(`ADCC_A_OFFSET, 32'h55);
    wr(`ADCC_A_GAIN_INT, 32'h66);
    wait_valid();
    level <= 24'($urandom);
    rd(`ADCC_A_STATUS, 32'h1);
    wait_valid();
    rd(`ADCC_A_RESULT, {8'h0, level});
    rd(`ADCC_A_STATUS, 32'h1);
    rd(`ADCC_A_OFFSET, {8'h0, OFS_F});
    rd(`ADCC_A_GAIN_INT, {8'h0, GN_F});
    wr(`ADCC_A_MODE, 32'h3);
    $display("test continuous done");

    r = $urandom & 32'h00ff_ffff;
    wr(`ADCC_A_OFFSET, r);
    wr(`ADCC_A_GAIN_EXT, r ^ 32'h1);
    wr(`ADCC_A_GAIN_SUP, r ^ 32'h2);
    rd(`ADCC_A_OFFSET, r);
    rd(`ADCC_A_GAIN_EXT, r ^ 32'h1);
    rd(`ADCC_A_GAIN_SUP, r ^ 32'h2);
    pga_unity <= 1'b1;
    for (int m = 4; m < 8; m++) begin
      src = (m == 7) ? 2'h3 : 2'(m - 3);
      level <= 24'($urandom);
      wr(`ADCC_A_MODE, 32'h3);
      nv = 0;
      wr(`ADCC_A_MODE, 32'(m));
      idle(2);
      chk(conv_src === src, "calibration source");
      wait_idle();
      chk(nv == (m[0] ? 6 : 3), "calibration length");
      rd(m[0] ? `ADCC_A_GAIN_INT : `ADCC_A_OFFSET,
         {8'h0, level ^ {src, 22'h0}});
      rd(`ADCC_A_STATUS, 32'h20, 32'h20);
      rd(`ADCC_A_STATUS, 32'h0, 32'h20);
      rd(`ADCC_A_MODE, 32'h3);
    end
    pga_unity <= 1'b0;
    wr(`ADCC_A_MODE, 32'h5);
    idle(2);
    rd(`ADCC_A_MODE, 32'h3);
    rd(`ADCC_A_STATUS, 32'h0, 32'h20);
    wr(`ADCC_A_MODE, 32'h0);
    idle(2);
    chk(adc_pwr_on === 1'b0 && mod_hold_rst === 1'b1, "pd");
    wr(`ADCC_A_MODE, 32'h3);
    $display("test calibration done");

    for (int k = 0; k < 3; k++) begin
      wr(`ADCC_A_DETCTL, 32'h20);
      {vpo, vno, vlow} <= 3'h1 << k;
      idle(2);
      {vpo, vno, vlow} <= 3'h0;
      rd(`ADCC_A_DETECTION_STATUS, 32'h8, 32'h8);
      rd(`ADCC_A_DETECTION_STATUS, 32'h0, 32'h8);
      wr(`ADCC_A_DETCTL, 32'h40);
      {vpo, vno, vlow} <= 3'h7;
      idle(3);
      {vpo, vno, vlow} <= 3'h0;
      rd(`ADCC_A_DETECTION_STATUS, 32'h0, 32'h8);
    end
    $display("test reference done");

    x  = 16'($urandom_range(16'h4000, 16'h1000));
    th = 10'($urandom_range(500, 1));
    fast_in <= x;
    nd = 0;
    wr(`ADCC_A_IRQMSK, 32'h2);
    wr(`ADCC_A_MODE, 32'h1);
    for (int o = 0; o < 4; o++) begin
      wr(`ADCC_A_DETCTL, 32'h0);
      wr(`ADCC_A_DETCTL, 32'h0204 | o);
      tick(t1);
      rd(`ADCC_A_DETECTION_STATUS, 32'h1, 32'h1);
      wait_tick(t2);
      chk(t2 - t1 == 200.0 * (o + 1), "fast period");
      rd(`ADCC_A_FAST, {16'h0, x});
    end
    chk(nd > 0 && fast_run === 1'b1, "dma pulse");
    wr(`ADCC_A_STEP_THRESHOLD, {22'h0, th});
    wr(`ADCC_A_IRQMSK, 32'h6);
    wr(`ADCC_A_DETCTL, 32'hc);
    repeat (3) tick(t1);
    fast_in <= x + 16'(th);
    tick(t1);
    rd(`ADCC_A_DETECTION_STATUS, 32'h1, 32'h3);
    fast_in <= x;
    repeat (3) tick(t1);
    fast_in <= x + 16'(th) + 16'h1;
    tick(t1);
    chk(irq_step === 1'b1, "step interrupt");
    rd(`ADCC_A_DETECTION_STATUS, 32'h3, 32'h3);
    idle(2);
    chk(irq_step === 1'b0, "step cleared");
    // Step against the latest main output
    fast_in <= x + 16'(th);
    level   <= {x, 8'h00};
    wr(`ADCC_A_DETCTL, 32'h1c);
    wait_valid();
    tick(t1);
    rd(`ADCC_A_DETECTION_STATUS, 32'h1, 32'h3);
    fast_in <= x + 16'(th) + 16'h1;
    tick(t1);
    rd(`ADCC_A_DETECTION_STATUS, 32'h3, 32'h3);
    $display("test fast filter done");

    wr(`ADCC_A_IRQMSK, 32'h1);
    rd(`ADCC_A_STATUS, 32'h1, 32'h1);
    wait_valid();
    idle(1);
    chk(irq_adc === 1'b1, "ready interrupt");
    wr(`ADCC_A_IRQMSK, 32'h0);
    idle(1);
    chk(irq_adc === 1'b0, "interrupt masked");
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(`ADCC_A_MODE, 32'h0);
    ce <= 1'b1;
    rd(`ADCC_A_MODE, 32'h1);
    idle(2);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule // test_adc_mode_calibration_step_detect

// [shared/adcc_consts.svh]
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// Register offsets on the plain register port
`define ADCC_A_MODE      4'h0
`define ADCC_A_FILT      4'h1
`define ADCC_A_STATUS    4'h2
`define ADCC_A_RESULT    4'h3
`define ADCC_A_OFFSET    4'h4
`define ADCC_A_GAIN_INT  4'h5
`define ADCC_A_GAIN_EXT  4'h6
`define ADCC_A_GAIN_SUP  4'h7
`define ADCC_A_DETCTL    4'h8
`define ADCC_A_DETECTION_STATUS    4'h9
`define ADCC_A_FAST      4'ha
`define ADCC_A_STEP_THRESHOLD    4'hb
`define ADCC_A_IRQMSK    4'hc

// Mode field codes
`define ADCC_MODE_PD     3'h0
`define ADCC_MODE_CONT   3'h1
`define ADCC_MODE_SINGLE 3'h2
`define ADCC_MODE_IDLE   3'h3
`define ADCC_MODE_IZERO  3'h4
`define ADCC_MODE_IFULL  3'h5
`define ADCC_MODE_SZERO  3'h6
`define ADCC_MODE_SFULL  3'h7

// Converter status bit positions
`define ADCC_ST_RDY      0
`define ADCC_ST_THR      2
`define ADCC_ST_ERR      4
`define ADCC_ST_CAL      5

// Detection status bit positions
`define ADCC_DS_NEW      0
`define ADCC_DS_STEP     1
`define ADCC_DS_REF      3

// Detection control fields
`define ADCC_DC_OSR_LO   0
`define ADCC_DC_FAST_EN  2
`define ADCC_DC_STEP_EN  3
`define ADCC_DC_VS_MAIN  4
`define ADCC_DC_REF_LO   5
`define ADCC_DC_DMA_LO   8

// Interrupt mask bits
`define ADCC_IM_RDY      0
`define ADCC_IM_FAST     1
`define ADCC_IM_STEP     2

// Reset values
`define ADCC_MODE_RST    3'h3
`define ADCC_FILT_RST    8'h00
`define ADCC_DETCTL_RST  16'h0000
`define ADCC_STEP_THRESHOLD_RST  10'h000

// Conversions per calibration
`define ADCC_ZCAL_CONV   3
`define ADCC_FCAL_CONV   6

// Fast filter minimum output period
`define ADCC_FAST_MIN_NS 2000000
`define ADCC_CLK_NS      25
`define ADCC_FAST_BASE_CYC (`ADCC_FAST_MIN_NS / `ADCC_CLK_NS)

`endif

// [shared/adcc_pkg.sv]
package adcc_pkg;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    ST_PD   = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_CONV = 4'b0100,
    ST_CAL  = 4'b1000
  } adcc_state_e;

  // Reference selection
  typedef enum logic [1:0] {
    REF_INT  = 2'h0,
    REF_EXT1 = 2'h1,
    REF_EXT2 = 2'h2,
    REF_SUP  = 2'h3
  } adcc_ref_e;

  // Input source that the datapath converts
  typedef enum logic [1:0] {
    SRC_NORMAL = 2'h0,
    SRC_IZERO  = 2'h1,
    SRC_IFULL  = 2'h2,
    SRC_SYSTEM = 2'h3
  } adcc_src_e;

  // One main filter output from the datapath
  typedef struct packed {
    logic        valid;
    logic [23:0] data;
    logic        range_err;
    logic        thresh;
  } adcc_main_s;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } adcc_req_s;

endpackage

// [src/adcc_ctrl.sv]
`timescale 1ns/1ps
`include "adcc_consts.svh"
// How it works
// [RULE_01] Single mode converts once, then idles
// [RULE_02] Continuous mode refreshes result at filter rate
// [RULE_03] Result-ready status bit set per conversion
// [RULE_04] Ready and fast outputs maskable onto interrupts
// [RULE_05] Range error sets status error bit
// [RULE_06] Host checks comparator-threshold status bit
// [RULE_07] Host idles converter before calibrating
// [RULE_08] Offset and gain writable only in idle
// [RULE_09] Internal zero calibration fills offset register
// [RULE_10] Internal full calibration, unity gain, double length
// [RULE_11] System zero calibration fills offset register
// [RULE_12] System full calibration fills gain register
// [RULE_13] Three gain registers; only internal one reloads
// [RULE_14] Idle keeps power, holds modulator in reset
// [RULE_15] Power-down switches converter and amplifiers off
// [RULE_16] External reference one faults set reference flag
// [RULE_17] Second external reference never flags faults
// [RULE_18] Fast filter parallel, own result, minimum period
// [RULE_19] Step versus two prior fast outputs
// [RULE_20] Alternative step versus latest main output
// [RULE_21] Step flag bit one; DMA count interrupt
// [RULE_22] New fast output flag bit zero
// [RULE_23] Two-bit fast oversampling select
// [RULE_24] Ten-bit step threshold register
// [RULE_25] Calibration flag sticky; new request restarts
module adcc_ctrl #(
  parameter int          FAST_BASE_CYC = `ADCC_FAST_BASE_CYC,
  parameter logic [23:0] OFFSET_FACT   = 24'h00_0000,
  parameter logic [23:0] GAIN_FACT     = 24'h40_0000
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire adcc_pkg::adcc_req_s bus,
  output logic [31:0]            rdata,
  input  wire adcc_pkg::adcc_main_s main_in,
  input  wire logic [15:0]       fast_in,
  input  wire logic              pga_unity,
  input  wire logic              vref_pos_open,
  input  wire logic              vref_neg_open,
  input  wire logic              vref_low,
  output logic                   adc_pwr_on,
  output logic                   mod_hold_rst,
  output logic                   main_sinc4,
  output logic                   fast_run,
  output logic [7:0]             filt_rate,
  output adcc_pkg::adcc_src_e    conv_src,
  output logic                   irq_adc,
  output logic                   irq_step,
  output logic                   irq_dma
);

  adcc_pkg::adcc_state_e state_r;
  logic [2:0]  mode_r;
  logic [2:0]  cal_code_r;
  logic [2:0]  cal_cnt_r;
  logic [7:0]  filt_r;
  logic [5:0]  sta_r;
  logic [23:0] result_r;
  logic [23:0] offset_r;
  logic [23:0] gain_int_r;
  logic [23:0] gain_ext_r;
  logic [23:0] gain_sup_r;
  logic [15:0] detctl_r;
  logic [3:0]  detection_status_r;
  logic [15:0] fast_r;
  logic [15:0] prev1_r;
  logic [15:0] prev2_r;
  logic [1:0]  hist_r;
  logic [9:0]  step_threshold_r;
  logic [2:0]  irqmsk_r;
  logic [19:0] fast_cnt_r;
  logic [7:0]  dma_cnt_r;
  logic        irq_dma_r;

  logic        wr_mode;
  logic        idle_ok;
  logic        conv_evt;
  logic        cal_evt;
  logic        cal_last;
  logic [2:0]  cal_need;
  logic        fast_tick;
  logic [19:0] fast_lim;
  logic        step_hit;
  logic        ref_fault;
  adcc_pkg::adcc_ref_e ref_sel;

  assign wr_mode  = ce && bus.wr && (bus.addr == `ADCC_A_MODE);
  assign idle_ok  = (mode_r == `ADCC_MODE_IDLE);
  assign conv_evt = ce && main_in.valid && (state_r == adcc_pkg::ST_CONV);
  assign cal_evt  = ce && main_in.valid && (state_r == adcc_pkg::ST_CAL);
  assign ref_sel  = adcc_pkg::adcc_ref_e'(detctl_r[`ADCC_DC_REF_LO +: 2]);

  // Full-scale calibrations run two stages, twice as long
  assign cal_need = (cal_code_r == `ADCC_MODE_IFULL ||
                     cal_code_r == `ADCC_MODE_SFULL) ?
                    3'(`ADCC_FCAL_CONV) : 3'(`ADCC_ZCAL_CONV); // RULE_10
  assign cal_last = cal_evt && (cal_cnt_r == cal_need - 3'h1);

  // Mode state machine and the mode field it returns to idle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= adcc_pkg::ST_IDLE;
      mode_r     <= `ADCC_MODE_RST;
      cal_code_r <= `ADCC_MODE_IDLE;
      cal_cnt_r  <= 3'h0;
    end else if (ce) begin
      if (wr_mode) begin
        mode_r    <= bus.wdata[2:0];
        cal_cnt_r <= 3'h0; // RULE_25
        unique case (bus.wdata[2:0])
          `ADCC_MODE_PD:     state_r <= adcc_pkg::ST_PD; // RULE_15
          `ADCC_MODE_CONT,
          `ADCC_MODE_SINGLE: state_r <= adcc_pkg::ST_CONV;
          `ADCC_MODE_IDLE:   state_r <= adcc_pkg::ST_IDLE;
          `ADCC_MODE_IFULL: begin
            // Internal gain calibration refused off unity gain
            if (pga_unity) begin // RULE_10
              state_r    <= adcc_pkg::ST_CAL;
              cal_code_r <= bus.wdata[2:0];
            end else begin
              state_r <= adcc_pkg::ST_IDLE;
              mode_r  <= `ADCC_MODE_IDLE;
            end
          end
          default: begin
            state_r    <= adcc_pkg::ST_CAL;
            cal_code_r <= bus.wdata[2:0];
          end
        endcase
      end else if (conv_evt && mode_r == `ADCC_MODE_SINGLE) begin
        state_r <= adcc_pkg::ST_IDLE; // RULE_01
        mode_r  <= `ADCC_MODE_IDLE; // RULE_14
      end else if (cal_last) begin
        state_r   <= adcc_pkg::ST_IDLE; // RULE_14
        mode_r    <= `ADCC_MODE_IDLE;
        cal_cnt_r <= 3'h0;
      end else if (cal_evt) begin
        cal_cnt_r <= cal_cnt_r + 3'h1;
      end
    end
  end

  // Result register, refreshed by every main conversion outside calibration
  always_ff @(posedge clk) begin
    if (rst) begin
      result_r <= 24'h00_0000;
    end else if (conv_evt) begin
      result_r <= main_in.data; // RULE_02
    end
  end

  // Converter status flags, read-clears, a set wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      sta_r <= 6'h00;
    end else if (ce) begin
      if (bus.rd && bus.addr == `ADCC_A_STATUS) begin
        sta_r <= 6'h00; // RULE_25
      end
      if (conv_evt) begin
        sta_r[`ADCC_ST_RDY] <= 1'b1; // RULE_03
      end
      if (conv_evt && main_in.range_err) begin
        sta_r[`ADCC_ST_ERR] <= 1'b1; // RULE_05
      end
      if (conv_evt && main_in.thresh) begin
        sta_r[`ADCC_ST_THR] <= 1'b1; // RULE_06
      end
      if (cal_last) begin
        sta_r[`ADCC_ST_CAL] <= 1'b1; // RULE_09
      end
    end
  end

  // Offset correction: software only in idle, else calibration
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_r <= OFFSET_FACT; // RULE_09
    end else if (ce) begin
      if (bus.wr && bus.addr == `ADCC_A_OFFSET && idle_ok) begin
        offset_r <= bus.wdata[23:0]; // RULE_08
      end else if (cal_last && (cal_code_r == `ADCC_MODE_IZERO ||
                                cal_code_r == `ADCC_MODE_SZERO)) begin
        offset_r <= main_in.data; // RULE_11
      end
    end
  end

  // Gain corrections: internal, external (both external pairs share one) and supply
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_int_r <= GAIN_FACT; // RULE_13
      gain_ext_r <= 24'h00_0000;
      gain_sup_r <= 24'h00_0000;
    end else if (ce) begin
      if (bus.wr && idle_ok) begin
        if (bus.addr == `ADCC_A_GAIN_INT) gain_int_r <= bus.wdata[23:0];
        if (bus.addr == `ADCC_A_GAIN_EXT) gain_ext_r <= bus.wdata[23:0];
        if (bus.addr == `ADCC_A_GAIN_SUP) gain_sup_r <= bus.wdata[23:0];
      end else if (cal_last && (cal_code_r == `ADCC_MODE_IFULL ||
                                cal_code_r == `ADCC_MODE_SFULL)) begin
        // Gain lands in the register of the active reference
        unique case (ref_sel) // RULE_12
          adcc_pkg::REF_INT: gain_int_r <= main_in.data;
          adcc_pkg::REF_SUP: gain_sup_r <= main_in.data;
          adcc_pkg::REF_EXT1,
          adcc_pkg::REF_EXT2: gain_ext_r <= main_in.data;
        endcase
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_r   <= `ADCC_FILT_RST;
      detctl_r <= `ADCC_DETCTL_RST;
      step_threshold_r <= `ADCC_STEP_THRESHOLD_RST;
      irqmsk_r <= 3'h0;
    end else if (ce && bus.wr) begin
      unique case (bus.addr)
        `ADCC_A_FILT:   filt_r   <= bus.wdata[7:0];
        `ADCC_A_DETCTL: detctl_r <= bus.wdata[15:0];
        `ADCC_A_STEP_THRESHOLD: step_threshold_r <= bus.wdata[9:0]; // RULE_24
        `ADCC_A_IRQMSK: irqmsk_r <= bus.wdata[2:0];
        default: ;
      endcase
    end
  end

  // Fast filter output period from the oversampling select
  assign fast_lim  = 20'(FAST_BASE_CYC) *
                     {18'h0_0000, detctl_r[`ADCC_DC_OSR_LO +: 2]}
                     + 20'(FAST_BASE_CYC); // RULE_23
  // Compare with >= so that lowering the rate mid-run cannot skip the end
  assign fast_tick = ce && fast_run && (fast_cnt_r >= fast_lim - 20'h0_0001);

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_cnt_r <= 20'h0_0000;
    end else if (ce) begin
      if (!fast_run || fast_tick) begin
        fast_cnt_r <= 20'h0_0000; // RULE_18
      end else begin
        fast_cnt_r <= fast_cnt_r + 20'h0_0001;
      end
    end
  end

  // Fast result and its two predecessors
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_r  <= 16'h0000;
      prev1_r <= 16'h0000;
      prev2_r <= 16'h0000;
      hist_r  <= 2'h0;
    end else if (fast_tick) begin
      fast_r  <= fast_in; // RULE_18
      prev1_r <= fast_in;
      prev2_r <= prev1_r;
      hist_r  <= {hist_r[0], 1'b1};
    end else if (ce && !fast_run) begin
      hist_r <= 2'h0;
    end
  end

  // Step compare against history or the latest main output
  function automatic logic over_th(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input logic [9:0]  th);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    if (d < 0) d = -d;
    return d > $signed({7'h00, th});
  endfunction

  always_comb begin
    step_hit = 1'b0;
    if (detctl_r[`ADCC_DC_STEP_EN]) begin
      if (detctl_r[`ADCC_DC_VS_MAIN]) begin
        step_hit = over_th(fast_in, result_r[23:8], step_threshold_r); // RULE_20
      end else begin
        step_hit = hist_r[1] &&
                   (over_th(fast_in, prev1_r, step_threshold_r) ||
                    over_th(fast_in, prev2_r, step_threshold_r)); // RULE_19
      end
    end
  end

  // Reference fault exists only for the first external pair
  assign ref_fault = (ref_sel == adcc_pkg::REF_EXT1) &&
                     (vref_pos_open || vref_neg_open || vref_low); // RULE_17

  // Detection status flags, read-clears, a set wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      detection_status_r <= 4'h0;
    end else if (ce) begin
      if (bus.rd && bus.addr == `ADCC_A_DETECTION_STATUS) begin
        detection_status_r <= 4'h0;
      end
      if (fast_tick) begin
        detection_status_r[`ADCC_DS_NEW] <= 1'b1; // RULE_22
      end
      if (fast_tick && step_hit) begin
        detection_status_r[`ADCC_DS_STEP] <= 1'b1; // RULE_21
      end
      if (ref_fault) begin
        detection_status_r[`ADCC_DS_REF] <= 1'b1; // RULE_16
      end
    end
  end

  // Fast sample count toward the DMA interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_cnt_r <= 8'h00;
      irq_dma_r <= 1'b0;
    end else if (ce) begin
      irq_dma_r <= 1'b0;
      if (fast_tick) begin
        if (dma_cnt_r + 8'h01 >= detctl_r[`ADCC_DC_DMA_LO +: 8]) begin
          dma_cnt_r <= 8'h00;
          irq_dma_r <= 1'b1; // RULE_21
        end else begin
          dma_cnt_r <= dma_cnt_r + 8'h01;
        end
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (bus.rd) begin
        unique case (bus.addr)
          `ADCC_A_MODE:     rdata <= {29'h0, mode_r};
          `ADCC_A_FILT:     rdata <= {24'h00_0000, filt_r};
          `ADCC_A_STATUS:   rdata <= {26'h0, sta_r};
          `ADCC_A_RESULT:   rdata <= {8'h00, result_r};
          `ADCC_A_OFFSET:   rdata <= {8'h00, offset_r};
          `ADCC_A_GAIN_INT: rdata <= {8'h00, gain_int_r};
          `ADCC_A_GAIN_EXT: rdata <= {8'h00, gain_ext_r};
          `ADCC_A_GAIN_SUP: rdata <= {8'h00, gain_sup_r};
          `ADCC_A_DETCTL:   rdata <= {16'h0000, detctl_r};
          `ADCC_A_DETECTION_STATUS:   rdata <= {28'h000_0000, detection_status_r};
          `ADCC_A_FAST:     rdata <= {16'h0000, fast_r};
          `ADCC_A_STEP_THRESHOLD:   rdata <= {22'h00_0000, step_threshold_r};
          `ADCC_A_IRQMSK:   rdata <= {29'h0, irqmsk_r};
          default:          rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Datapath control
  assign adc_pwr_on   = (state_r != adcc_pkg::ST_PD); // RULE_15
  assign mod_hold_rst = (state_r == adcc_pkg::ST_PD) ||
                        (state_r == adcc_pkg::ST_IDLE); // RULE_14
  assign main_sinc4   = filt_r[7];
  assign fast_run     = detctl_r[`ADCC_DC_FAST_EN] && !mod_hold_rst;
  assign filt_rate    = filt_r; // RULE_02
  assign conv_src     = (state_r != adcc_pkg::ST_CAL) ? adcc_pkg::SRC_NORMAL :
                        (cal_code_r == `ADCC_MODE_IZERO) ? adcc_pkg::SRC_IZERO :
                        (cal_code_r == `ADCC_MODE_IFULL) ? adcc_pkg::SRC_IFULL :
                        adcc_pkg::SRC_SYSTEM;

  // Ready and step interrupt lines gated by the mask bits; the DMA pulse is not masked
  assign irq_adc  = (irqmsk_r[`ADCC_IM_RDY] && sta_r[`ADCC_ST_RDY]) ||
                    (irqmsk_r[`ADCC_IM_FAST] &&
                     detection_status_r[`ADCC_DS_NEW]); // RULE_04
  assign irq_step = irqmsk_r[`ADCC_IM_STEP] && detection_status_r[`ADCC_DS_STEP];
  assign irq_dma  = irq_dma_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  chk_single_idle: assert property ( // RULE_01
    conv_evt && mode_r == `ADCC_MODE_SINGLE && !wr_mode |=>
    state_r == adcc_pkg::ST_IDLE && mode_r == `ADCC_MODE_IDLE)
    else $error("single conversion did not return to idle");
  chk_ready_set: assert property ( // RULE_03
    conv_evt |=> sta_r[`ADCC_ST_RDY] && result_r == $past(main_in.data))
    else $error("result ready not set with new result");
  chk_range_err: assert property ( // RULE_05
    conv_evt && main_in.range_err |=> sta_r[`ADCC_ST_ERR])
    else $error("range error not flagged");
  chk_offset_lock: assert property ( // RULE_08
    bus.wr && bus.addr == `ADCC_A_OFFSET && !idle_ok && !cal_last
    |=> $stable(offset_r))
    else $error("offset written outside idle");
  chk_cal_done: assert property ( // RULE_09
    cal_last && !wr_mode |=> sta_r[`ADCC_ST_CAL] &&
    state_r == adcc_pkg::ST_IDLE && mod_hold_rst)
    else $error("calibration end not flagged");
  chk_ref2_quiet: assert property ( // RULE_17
    ref_sel != adcc_pkg::REF_EXT1 && !detection_status_r[`ADCC_DS_REF]
    |=> !detection_status_r[`ADCC_DS_REF])
    else $error("reference flag set off first external pair");
  chk_pd_off: assert property ( // RULE_15
    state_r == adcc_pkg::ST_PD |-> !adc_pwr_on && mod_hold_rst)
    else $error("power-down leaves converter on");
  chk_step_flag: assert property ( // RULE_19
    fast_tick && step_hit |=> detection_status_r[`ADCC_DS_STEP] &&
    (irq_step == irqmsk_r[`ADCC_IM_STEP]))
    else $error("step not flagged");
  chk_fast_new: assert property ( // RULE_22
    fast_tick |=> detection_status_r[`ADCC_DS_NEW] && fast_r == $past(fast_in))
    else $error("fast output not flagged");

  cov_single: cover property (wr_mode && bus.wdata[2:0] ==
    `ADCC_MODE_SINGLE ##[1:1000] conv_evt);
  cov_cal: cover property (cal_last);
  cov_step: cover property (fast_tick && step_hit);

endmodule // adcc_ctrl
